//--- rtl/lcdi_decoder.v
// Write-only two-wire slave receiver and command decoder with an
// AXI4-Lite register window. Assumes SCL, SDA, straps, subaddress pins
// and the display clock arrive asynchronously; the open-drain SDA pad
// is resolved outside from sda_oe.
`timescale 1ns/100ps
`include "lcdi_regs.vh"

module lcdi_decoder #(
	parameter RAM_DEPTH = 6'h28
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe,
	input wire addr_strap_level,
	input wire hw_subaddr_pin0,
	input wire hw_subaddr_pin1,
	input wire hw_subaddr_pin2,
	input wire lcd_clk_in,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire drive_mode_hi,
	output wire drive_mode_lo,
	output wire bias_half,
	output wire disp_enable,
	output wire flash_rate_hi,
	output wire flash_rate_lo,
	output wire blink_alt,
	output wire in_bank,
	output wire out_bank,
	output wire [5:0] pointer_value,
	output wire [2:0] subaddr_count,
	output wire display_blank,
	output wire shown_bank,
	output wire ram_wr,
	output wire [5:0] ram_addr,
	output wire ram_bank,
	output wire [7:0] ram_data
);

	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_CMD = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_IGNORE = 3'h4;

	// Pointer step for a drive mode
	function [5:0] step_of;
		input [1:0] mode;
		begin
			case (mode)
			`LCDI_MODE_STATIC: step_of = `LCDI_STEP_STATIC;
			`LCDI_MODE_MUX2: step_of = `LCDI_STEP_MUX2;
			`LCDI_MODE_MUX3: step_of = `LCDI_STEP_MUX3;
			default: step_of = `LCDI_STEP_MUX4;
			endcase
		end
	endfunction

	// Banks exist only where a RAM word holds spare bits
	function has_banks;
		input [1:0] mode;
		begin
			has_banks = (mode == `LCDI_MODE_STATIC) ||
				(mode == `LCDI_MODE_MUX2);
		end
	endfunction

	// Pins: scl, sda, strap, subaddress x3, display clock
	wire [6:0] pin_in;
	reg [6:0] sync_m_reg;
	reg [6:0] sync_s_reg;
	reg [6:0] sync_d_reg;
	assign pin_in = {lcd_clk_in, hw_subaddr_pin2, hw_subaddr_pin1,
		hw_subaddr_pin0, addr_strap_level, sda_i, scl_i};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
			always @(posedge aclk) begin
				if (!aresetn) begin
					sync_m_reg[gi] <= 1'b1;
					sync_s_reg[gi] <= 1'b1;
					sync_d_reg[gi] <= 1'b1;
				end else if (ce) begin
					sync_m_reg[gi] <= pin_in[gi];
					sync_s_reg[gi] <= sync_m_reg[gi];
					sync_d_reg[gi] <= sync_s_reg[gi];
				end
			end
		end
	endgenerate

	wire scl_s = sync_s_reg[0];
	wire scl_d = sync_d_reg[0];
	wire sda_s = sync_s_reg[1];
	wire sda_d = sync_d_reg[1];
	wire strap_s = sync_s_reg[2];
	wire [2:0] sub_s = sync_s_reg[5:3];
	wire lclk_rise = sync_s_reg[6] & ~sync_d_reg[6];

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	reg [2:0] state_reg;
	reg [2:0] bit_cnt_reg;
	reg [6:0] shift_reg;
	reg byte_end_reg;
	reg ack_phase_reg;
	reg ack_pending_reg;
	reg sda_drive_reg;
	reg slave_en_reg;

	reg [1:0] mode_reg;
	reg bias_reg;
	reg enable_reg;
	reg [5:0] ptr_reg;
	reg [2:0] sub_reg;
	reg in_bank_reg;
	reg out_bank_reg;
	reg alt_reg;
	reg [1:0] rate_reg;
	reg ram_wr_reg;
	reg [5:0] ram_addr_reg;
	reg ram_bank_reg;
	reg [7:0] ram_data_reg;
	reg [7:0] stored_cnt_reg;

	wire [7:0] byte_in = {shift_reg, sda_s};
	wire addr_match = (byte_in[7:2] == `LCDI_ADDR_FIXED) &&
		(byte_in[1] == strap_s) && !byte_in[0];
	wire sub_match = (sub_s == sub_reg);
	wire [6:0] ptr_sum = {1'b0, ptr_reg} + {1'b0, step_of(mode_reg)};
	wire ptr_wrap = (ptr_sum >= {1'b0, RAM_DEPTH});

	// Bit and byte framing of the serial link
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 3'h0;
			shift_reg <= 7'h00;
			byte_end_reg <= 1'b0;
			ack_phase_reg <= 1'b0;
			ack_pending_reg <= 1'b0;
			sda_drive_reg <= 1'b0;
		end else if (ce) begin
			if (bus_start || bus_stop) begin
				// Repeated START also lands here
				state_reg <= bus_start ? ST_ADDR : ST_IDLE;
				bit_cnt_reg <= 3'h0;
				byte_end_reg <= 1'b0;
				ack_phase_reg <= 1'b0;
				ack_pending_reg <= 1'b0;
				sda_drive_reg <= 1'b0;
			end else if (scl_rise && !ack_phase_reg &&
				(state_reg == ST_ADDR || state_reg == ST_CMD ||
				state_reg == ST_DATA)) begin
				shift_reg <= byte_in[6:0];
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7) begin
					byte_end_reg <= 1'b1;
					case (state_reg)
					ST_ADDR: begin
						ack_pending_reg <= addr_match && slave_en_reg;
						state_reg <= (addr_match && slave_en_reg) ?
							ST_CMD : ST_IGNORE;
					end
					ST_CMD: begin
						ack_pending_reg <= 1'b1;
						if (!byte_in[7])
							state_reg <= ST_DATA;
					end
					ST_DATA: begin
						ack_pending_reg <= sub_match;
					end
					default: begin
						ack_pending_reg <= 1'b0;
					end
					endcase
				end
			end else if (scl_fall) begin
				if (byte_end_reg) begin
					byte_end_reg <= 1'b0;
					ack_phase_reg <= 1'b1;
					sda_drive_reg <= ack_pending_reg;
				end else if (ack_phase_reg) begin
					// Release after the ninth clock's low edge
					ack_phase_reg <= 1'b0;
					sda_drive_reg <= 1'b0;
					bit_cnt_reg <= 3'h0;
				end
			end
		end
	end

	wire byte_done = ce && !bus_start && !bus_stop && scl_rise &&
		!ack_phase_reg && (bit_cnt_reg == 3'h7);
	wire cmd_done = byte_done && (state_reg == ST_CMD);
	wire data_done = byte_done && (state_reg == ST_DATA);

	// Command execution and display data placement; settings change only on
	// reset or a later command, pointer and subaddress also on data bytes
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= `LCDI_RST_MODE;
			bias_reg <= 1'b0;
			enable_reg <= 1'b0;
			ptr_reg <= `LCDI_RST_PTR;
			sub_reg <= `LCDI_RST_SUB;
			in_bank_reg <= 1'b0;
			out_bank_reg <= 1'b0;
			alt_reg <= 1'b0;
			rate_reg <= `LCDI_RST_RATE;
			ram_wr_reg <= 1'b0;
			ram_addr_reg <= 6'h00;
			ram_bank_reg <= 1'b0;
			ram_data_reg <= 8'h00;
			stored_cnt_reg <= 8'h00;
		end else if (ce) begin
			ram_wr_reg <= 1'b0;
			if (cmd_done) begin
				if (!byte_in[6]) begin
					ptr_reg <= byte_in[5:0];
				end else if (byte_in[6:5] == 2'h2) begin
					enable_reg <= byte_in[3];
					bias_reg <= byte_in[2];
					mode_reg <= byte_in[1:0];
				end else if (byte_in[6:3] == 4'hC) begin
					sub_reg <= byte_in[2:0];
				end else if (byte_in[6:3] == 4'hE) begin
					alt_reg <= byte_in[2];
					rate_reg <= byte_in[1:0];
				end else if (byte_in[6:2] == 5'h1E &&
					has_banks(mode_reg)) begin
					in_bank_reg <= byte_in[1];
					out_bank_reg <= byte_in[0];
				end
			end
			if (data_done) begin
				// Every addressed device tracks the position
				if (sub_match) begin
					ram_wr_reg <= 1'b1;
					ram_addr_reg <= ptr_reg;
					ram_bank_reg <= in_bank_reg & has_banks(mode_reg);
					ram_data_reg <= byte_in;
					stored_cnt_reg <= stored_cnt_reg + 8'h01;
				end
				if (ptr_wrap) begin
					ptr_reg <= 6'h00;
					sub_reg <= sub_reg + 3'h1;
				end else begin
					ptr_reg <= ptr_sum[5:0];
				end
			end
		end
	end

	// Blink timebase counted on display clock edges
	reg [11:0] blink_cnt_reg;
	reg blink_phase_reg;
	reg blank_reg;
	reg shown_bank_reg;
	reg [11:0] blink_half;

	always @* begin
		case (rate_reg)
		`LCDI_RATE_FAST: blink_half = `LCDI_DIV_FAST >> 1;
		`LCDI_RATE_MID: blink_half = `LCDI_DIV_MID >> 1;
		default: blink_half = `LCDI_DIV_SLOW >> 1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_reg <= 12'h000;
			blink_phase_reg <= 1'b0;
			blank_reg <= 1'b1;
			shown_bank_reg <= 1'b0;
		end else if (ce) begin
			if (rate_reg == `LCDI_RATE_OFF) begin
				blink_cnt_reg <= 12'h000;
				blink_phase_reg <= 1'b0;
			end else if (lclk_rise) begin
				if (blink_cnt_reg >= blink_half - 12'h001) begin
					blink_cnt_reg <= 12'h000;
					blink_phase_reg <= ~blink_phase_reg;
				end else begin
					blink_cnt_reg <= blink_cnt_reg + 12'h001;
				end
			end
			// Alternate-bank blinking falls back to normal in 1:3, 1:4
			if (alt_reg && has_banks(mode_reg)) begin
				blank_reg <= ~enable_reg;
				shown_bank_reg <= out_bank_reg ^ blink_phase_reg;
			end else begin
				blank_reg <= ~enable_reg | blink_phase_reg;
				shown_bank_reg <= out_bank_reg & has_banks(mode_reg);
			end
		end
	end

	// AXI4-Lite slave: address and data taken in either order
	reg aw_held_reg;
	reg w_held_reg;
	reg [3:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rd_word;
	reg rd_hit;

	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
	assign s_axi_arready = ~rvalid_reg;

	always @* begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
		`LCDI_OFF_CTRL:
			rd_word[`LCDI_CTRL_ENABLE_BIT] = slave_en_reg;
		`LCDI_OFF_SETTINGS: begin
			rd_word[`LCDI_SET_MODE_LSB+1:`LCDI_SET_MODE_LSB] = mode_reg;
			rd_word[`LCDI_SET_BIAS_BIT] = bias_reg;
			rd_word[`LCDI_SET_ENABLE_BIT] = enable_reg;
			rd_word[`LCDI_SET_IN_BANK_BIT] = in_bank_reg;
			rd_word[`LCDI_SET_OUT_BANK_BIT] = out_bank_reg;
			rd_word[`LCDI_SET_RATE_LSB+1:`LCDI_SET_RATE_LSB] = rate_reg;
			rd_word[`LCDI_SET_ALT_BIT] = alt_reg;
		end
		`LCDI_OFF_POSITION: begin
			rd_word[`LCDI_POS_PTR_LSB+5:`LCDI_POS_PTR_LSB] = ptr_reg;
			rd_word[`LCDI_POS_SUB_LSB+2:`LCDI_POS_SUB_LSB] = sub_reg;
			rd_word[`LCDI_POS_PHASE_BIT] = blink_phase_reg;
		end
		`LCDI_OFF_STATUS: begin
			rd_word[`LCDI_STA_ACTIVE_BIT] = (state_reg != ST_IDLE);
			rd_word[`LCDI_STA_DATA_BIT] = (state_reg == ST_DATA);
			rd_word[`LCDI_STA_COUNT_LSB+7:`LCDI_STA_COUNT_LSB] =
				stored_cnt_reg;
		end
		default:
			rd_hit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `LCDI_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `LCDI_RESP_OKAY;
			rdata_reg <= 32'h00000000;
			slave_en_reg <= `LCDI_CTRL_RESET;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_held_reg && w_held_reg) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (aw_addr_reg[3:2] == 2'h0 ||
					aw_addr_reg == `LCDI_OFF_SETTINGS ||
					aw_addr_reg == `LCDI_OFF_POSITION ||
					aw_addr_reg == `LCDI_OFF_STATUS) &&
					(aw_addr_reg[1:0] == 2'h0) ?
					`LCDI_RESP_OKAY : `LCDI_RESP_SLVERR;
				// Only the control word is writable
				if (aw_addr_reg == `LCDI_OFF_CTRL && w_strb_reg[0])
					slave_en_reg <= w_data_reg[`LCDI_CTRL_ENABLE_BIT];
			end
			if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_word;
				rresp_reg <= rd_hit ? `LCDI_RESP_OKAY : `LCDI_RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	// Open drain: only ever pulls low, never transmits data
	assign sda_o = 1'b0;
	assign sda_oe = sda_drive_reg;

	assign drive_mode_hi = mode_reg[1];
	assign drive_mode_lo = mode_reg[0];
	assign bias_half = bias_reg;
	assign disp_enable = enable_reg;
	assign flash_rate_hi = rate_reg[1];
	assign flash_rate_lo = rate_reg[0];
	assign blink_alt = alt_reg;
	assign in_bank = in_bank_reg;
	assign out_bank = out_bank_reg;
	assign pointer_value = ptr_reg;
	assign subaddr_count = sub_reg;
	assign display_blank = blank_reg;
	assign shown_bank = shown_bank_reg;
	assign ram_wr = ram_wr_reg;
	assign ram_addr = ram_addr_reg;
	assign ram_bank = ram_bank_reg;
	assign ram_data = ram_data_reg;

endmodule // lcdi_decoder

//--- rtl/lcdi_regs.vh
// Constants of the segment display command decoder.
// Assumes inclusion by bare name from the design file.
`ifndef LCDI_REGS_VH
`define LCDI_REGS_VH

// Register byte offsets
`define LCDI_OFF_CTRL 4'h0
`define LCDI_OFF_SETTINGS 4'h4
`define LCDI_OFF_POSITION 4'h8
`define LCDI_OFF_STATUS 4'hC

// Control register fields and reset
`define LCDI_CTRL_ENABLE_BIT 0
`define LCDI_CTRL_RESET 1'h1

// Settings register field positions
`define LCDI_SET_MODE_LSB 0
`define LCDI_SET_BIAS_BIT 2
`define LCDI_SET_ENABLE_BIT 3
`define LCDI_SET_IN_BANK_BIT 4
`define LCDI_SET_OUT_BANK_BIT 5
`define LCDI_SET_RATE_LSB 6
`define LCDI_SET_ALT_BIT 8

// Position register field positions
`define LCDI_POS_PTR_LSB 0
`define LCDI_POS_SUB_LSB 8
`define LCDI_POS_PHASE_BIT 16

// Status register field positions
`define LCDI_STA_ACTIVE_BIT 0
`define LCDI_STA_DATA_BIT 1
`define LCDI_STA_COUNT_LSB 8

// Bus responses
`define LCDI_RESP_OKAY 2'h0
`define LCDI_RESP_SLVERR 2'h2

// Slave address: six fixed bits, then strap bit, then write bit
`define LCDI_ADDR_FIXED 6'h1C

// Drive mode codes
`define LCDI_MODE_STATIC 2'h1
`define LCDI_MODE_MUX2 2'h2
`define LCDI_MODE_MUX3 2'h3
`define LCDI_MODE_MUX4 2'h0

// Pointer advance per data byte, stored or not
`define LCDI_STEP_STATIC 6'h08
`define LCDI_STEP_MUX2 6'h04
`define LCDI_STEP_MUX3 6'h03
`define LCDI_STEP_MUX4 6'h02

// Blink rate codes and divisors of the display clock
`define LCDI_RATE_OFF 2'h0
`define LCDI_RATE_FAST 2'h1
`define LCDI_RATE_MID 2'h2
`define LCDI_DIV_FAST 12'h300
`define LCDI_DIV_MID 12'h600
`define LCDI_DIV_SLOW 12'hC00

// Power-on settings
`define LCDI_RST_MODE 2'h0
`define LCDI_RST_PTR 6'h00
`define LCDI_RST_SUB 3'h0
`define LCDI_RST_RATE 2'h0

`endif

//--- testbench/lcdi_checker.sv
// Port-level checks of the decoder, bound to its top module.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/100ps
module lcdi_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic drive_mode_hi,
	input wire logic drive_mode_lo,
	input wire logic disp_enable,
	input wire logic flash_rate_hi,
	input wire logic flash_rate_lo,
	input wire logic in_bank,
	input wire logic out_bank,
	input wire logic display_blank,
	input wire logic ram_wr,
	input wire logic ram_bank
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// 1:3 and 1:4 have no spare bank
	wire m34 = ~(drive_mode_hi ^ drive_mode_lo);
	wire rate_off = ~(flash_rate_hi | flash_rate_lo);
	property p_sda_o; sda_o == 1'b0; endproperty
	a_sda_o: assert property (p_sda_o)
		else $error("data pin driven high");
	property p_oe_rise; $rose(sda_oe) |-> !scl_i; endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("acknowledge starts with clock high");
	property p_oe_hold; sda_oe && scl_i |=> sda_oe || !scl_i; endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("acknowledge dropped in clock high");
	property p_oe_len; $rose(sda_oe) |-> sda_oe [*6]; endproperty
	a_oe_len: assert property (p_oe_len)
		else $error("acknowledge too short");
	property p_wr_pulse; ram_wr |=> !ram_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("store strobe longer than one cycle");
	property p_wr_bank;
		ram_wr |-> ram_bank == (in_bank && !m34);
	endproperty
	a_wr_bank: assert property (p_wr_bank)
		else $error("store bank wrong");
	property p_bank_fix; $past(m34) |-> $stable({in_bank, out_bank}); endproperty
	a_bank_fix: assert property (p_bank_fix)
		else $error("bank changed in 1:3 or 1:4");
	property p_blank;
		$past(rate_off, 2) && $past(rate_off) && rate_off &&
			$stable(disp_enable)
			|-> display_blank == !disp_enable;
	endproperty
	a_blank: assert property (p_blank)
		else $error("blanking does not follow enable");
	property p_wlat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_wlat: assert property (p_wlat)
		else $error("write response late");
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat)
		else $error("read data late");
	c_store: cover property (ram_wr);
	c_ack: cover property ($rose(sda_oe));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule // lcdi_checker

bind lcdi_decoder lcdi_checker u_chk (.*);

//--- testbench/lcdi_i2c_master.sv
// Two-wire bus master model writing address, commands and data.
// Assumes pull-ups; the bench resolves SDA from sda_low and the slave.
`timescale 1ns/100ps
module lcdi_i2c_master (
	input wire logic aclk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	// Phases well above the slave's synchroniser lag
	localparam int PH = 6;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Also serves as repeated start
	task automatic start_bit;
		scl <= 1'b0;
		sda_low <= 1'b0;
		w(PH);
		scl <= 1'b1;
		w(PH);
		sda_low <= 1'b1;
		w(PH);
		scl <= 1'b0;
		w(2);
	endtask
	task automatic stop_bit;
		scl <= 1'b0;
		sda_low <= 1'b1;
		w(PH);
		scl <= 1'b1;
		w(PH);
		sda_low <= 1'b0;
		w(PH);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			w(PH);
			scl <= 1'b1;
			w(PH);
			scl <= 1'b0;
			w(2);
		end
		sda_low <= 1'b0;
		w(PH);
		scl <= 1'b1;
		w(3);
		ack = ~sda_line;
		w(PH - 3);
		scl <= 1'b0;
		w(2);
	endtask
endmodule // lcdi_i2c_master

//--- testbench/tb_lcd_driver_i2c_command_decoder.sv
// Self-checking bench: bus frames from the master model, register reads.
// Assumes lcdi_i2c_master and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "lcdi_regs.vh"
module tb_lcd_driver_i2c_command_decoder;
	logic aclk, aresetn, ce, scl_i, addr_strap_level, lcd_clk_in;
	logic hw_subaddr_pin0, hw_subaddr_pin1, hw_subaddr_pin2;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, div;
	logic drive_mode_hi, drive_mode_lo, bias_half, disp_enable, blink_alt;
	logic flash_rate_hi, flash_rate_lo, in_bank, out_bank, display_blank;
	logic shown_bank, ram_wr, ram_bank, sda_o, sda_oe, sda_low;
	logic [5:0] pointer_value, ram_addr, wa;
	logic [2:0] subaddr_count;
	logic [7:0] ram_data, wd;
	int err_count = 0, checks = 0, wr_cnt = 0, edges = 0;
	// Static, enabled, both banks, fast normal blink
	localparam logic [31:0] SET_EXP = 32'h79;
	wire sda_i = ~(sda_low | sda_oe);
	lcdi_decoder dut (.*);
	lcdi_i2c_master m (.aclk(aclk), .sda_line(sda_i), .scl(scl_i),
		.sda_low(sda_low));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Fast display clock so blink periods stay short
	always @(posedge aclk) begin
		div <= div + 2'h1;
		if (div == 2'h3) lcd_clk_in <= ~lcd_clk_in;
		if (div == 2'h3 && !lcd_clk_in) edges <= edges + 1;
		if (ram_wr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wa <= ram_addr;
			wd <= ram_data;
		end
	end
	task automatic complete_run;
		$display("mismatches %0d, checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tmo;
		err_count++;
		complete_run();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input string s);
		checks++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t ns: %s got %0h expected %0h",
				$time, s, g, x);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (s_axi_bvalid !== 1'b1) tmo();
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (s_axi_rvalid !== 1'b1) tmo();
	endtask
	task automatic sendb(input logic [7:0] b, input logic e);
		logic a;
		m.put_byte(b, a);
		chk(32'(a), 32'(e), "acknowledge");
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk(32'({drive_mode_hi, drive_mode_lo, disp_enable, display_blank}),
			32'h1, "reset mode");
		chk(32'({subaddr_count, pointer_value}), 32'h0, "reset ptr");
		axi_rd(`LCDI_OFF_CTRL, d, r);
		chk(d, 32'h1, "control reset");
		axi_rd(`LCDI_OFF_SETTINGS, d, r);
		chk(d, 32'h0, "settings reset");
	endtask
	task automatic t_addr;
		for (int s = 0; s < 2; s++) begin
			addr_strap_level <= s[0];
			for (int k = 0; k < 4; k++) begin
				m.start_bit();
				sendb(8'h70 + 8'(k), 1'(k == 2 * s));
				if (k != 2 * s) sendb(8'h0A, 1'b0);
				m.stop_bit();
			end
		end
		addr_strap_level <= 1'b0;
		chk(32'(pointer_value), 32'h0, "ignored frame");
	endtask
	task automatic t_steps;
		int st[4] = '{2, 8, 4, 3};
		int c;
		for (int k = 0; k < 4; k++) begin
			c = wr_cnt;
			m.start_bit();
			sendb(8'h70, 1'b1);
			sendb(8'hC8 + 8'(k) + 8'(4 * (k % 2)), 1'b1);
			sendb(8'hE0, 1'b1);
			sendb(8'h04, 1'b1);
			sendb(8'hA0 + 8'(k), 1'b1);
			m.stop_bit();
			chk(32'({drive_mode_hi, drive_mode_lo}), 32'(k), "mode");
			chk(32'({bias_half, disp_enable}), 32'(2 * (k % 2) + 1),
				"bias");
			chk(32'(pointer_value), 32'(4 + st[k]), "pointer");
			chk(32'({wa, wd}), 32'({6'h04, 8'hA0 + 8'(k)}), "store");
			chk(wr_cnt - c, 1, "store count");
		end
		for (int p = 0; p < 2; p++) begin
			c = wr_cnt;
			{hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0} <= 3'(2 * p);
			m.start_bit();
			sendb(8'h70, 1'b1);
			sendb(8'hE2, 1'b1);
			sendb(8'h10, 1'b1);
			sendb(8'h66, 1'(p));
			m.stop_bit();
			chk(32'({subaddr_count, pointer_value}), 32'({3'h2, 6'h13}),
				"advance");
			chk(wr_cnt - c, p, "store count");
		end
		{hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0} <= 3'h0;
	endtask
	task automatic t_blink;
		int e0 = 0;
		int n;
		m.start_bit();
		sendb(8'h70, 1'b1);
		sendb(8'hC9, 1'b1);
		sendb(8'hFB, 1'b1);
		chk(32'({in_bank, out_bank}), 32'h3, "banks");
		for (int r = 0; r < 4; r++) begin
			sendb(8'hF4 + 8'(r), 1'b1);
			chk(32'({blink_alt, flash_rate_hi, flash_rate_lo}), 32'(4 + r),
				"blink");
		end
		sendb(8'hC8, 1'b1);
		sendb(8'hF8, 1'b1);
		sendb(8'hC9, 1'b1);
		sendb(8'hF1, 1'b1);
		sendb(8'hE0, 1'b1);
		sendb(8'h00, 1'b1);
		sendb(8'h5A, 1'b1);
		m.stop_bit();
		chk(32'({in_bank, out_bank}), 32'h3, "banks held");
		chk(32'({ram_bank, wd}), 32'({1'b1, 8'h5A}), "bank store");
		chk(32'(shown_bank), 32'h1, "shown bank");
		for (int k = 0; k < 2; k++) begin
			logic v;
			v = display_blank;
			n = 0;
			while (display_blank === v && n < 8000) begin
				@(posedge aclk);
				n++;
			end
			if (n >= 8000) tmo();
			if (k == 1) chk(edges - e0, 384, "half period");
			e0 = edges;
		end
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(`LCDI_OFF_SETTINGS, d, r);
		chk(d, SET_EXP, "settings");
		axi_wr(`LCDI_OFF_SETTINGS, 32'h0, r);
		chk(32'(r), 32'(`LCDI_RESP_OKAY), "read-only write");
		axi_rd(4'h2, d, r);
		chk(d, 32'h0, "unaligned data");
		chk(32'(r), 32'(`LCDI_RESP_SLVERR), "unaligned response");
		axi_wr(`LCDI_OFF_CTRL, 32'h0, r);
		m.start_bit();
		sendb(8'h70, 1'b0);
		m.stop_bit();
		axi_wr(`LCDI_OFF_CTRL, 32'h1, r);
		m.start_bit();
		sendb(8'h70, 1'b1);
		sendb(8'h00, 1'b1);
		m.stop_bit();
		axi_rd(`LCDI_OFF_SETTINGS, d, r);
		chk(d, SET_EXP, "settings kept");
		// Reset in mid-run must clear every setting again
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_reset();
	endtask
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		addr_strap_level = 1'b0;
		{hw_subaddr_pin2, hw_subaddr_pin1, hw_subaddr_pin0} = 3'h0;
		lcd_clk_in = 1'b0;
		div = 2'h0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		t_reset();
		t_addr();
		t_steps();
		t_blink();
		t_regs();
		complete_run();
	end
endmodule // tb_lcd_driver_i2c_command_decoder
